// [pti_top.sv]
/*
 * Proximity threshold interrupt logic: threshold compare, persistence,
 * hysteresis, three interrupt modes, low-power periodic sampling, and an
 * Avalon-MM register slave with a maskable interrupt.
 * Assumes the measurement link delivers a 12-bit count that is stable
 * around each rising edge of its own slow clock.
 */
// Notes on behaviour
// - Registers hold defaults from reset; mode resets to off, so setup is needed.
// - Mode field 1:0 selects first-high mode.
// - First-high: low events ignored until high event.
// - First-high: event stays latched until flag read.
// - Mode field 1:1 selects normal both-threshold mode.
// - Mode field 0:1 selects logic high/low mode.
// - Logic mode: pin low when count reaches high.
// - Logic mode: pin released when count below low.
// - Persistence: 1 to 4 consecutive samples required.
// - Low-power enable measures periodically, up to 320 ms.
// - Between thresholds: no new interrupt, state unchanged.
// - Flag bit 1 near event, bit 0 far event.
// - Period codes 00..11 give 40/80/160/320 ms.
`default_nettype none

module pti_top #(
	parameter int COUNT_W = 12,
	parameter int LP_BASE_CYCLES = pti_pkg::LP_BASE_CYC
) (
	input wire logic i_mclk, // System clock, 250 MHz.
	input wire logic i_arst_n, // Asynchronous reset, active low.
	input wire logic [4:0] i_address, // Avalon byte address.
	input wire logic i_read, // Avalon read request.
	input wire logic i_write, // Avalon write request.
	input wire logic [31:0] i_writedata, // Avalon write data.
	input wire logic [3:0] i_byteenable, // Avalon byte enables.
	output logic [31:0] o_readdata, // Avalon read data.
	output logic o_waitrequest, // Avalon wait request.
	output logic o_irq, // Level interrupt to the system.
	input wire logic i_meas_clk, // Measurement link clock.
	input wire logic [COUNT_W-1:0] i_meas_count, // Proximity count.
	output logic o_meas_req, // Low-power measurement request pulse.
	input wire logic i_int_in, // Interrupt pin level.
	output logic o_int_out, // Interrupt pin drive value.
	output logic o_int_oe_n // Interrupt pin enable, low drives.
);

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------

	// Consecutive samples needed for a persistence code.
	function automatic logic [2:0] persist_need(input logic [1:0] code);
		persist_need = {1'b0, code} + 3'h1;
	endfunction

	// Saturating run counter step.
	function automatic logic [2:0] run_step(input logic hit, input logic [2:0] run);
		if (!hit) begin
			run_step = 3'h0;
		end else if (run == 3'h7) begin
			run_step = run;
		end else begin
			run_step = run + 3'h1;
		end
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [8:0] ctrl_q;
	logic [11:0] thr_hi_q;
	logic [11:0] thr_lo_q;
	logic [1:0] flags_q;
	logic [1:0] flags_d;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_stat_d;
	logic [1:0] irq_mask_q;
	logic near_state_q;
	logic near_state_d;
	logic armed_q;
	logic armed_d;
	logic [2:0] hi_run_q;
	logic [2:0] lo_run_q;
	logic [COUNT_W-1:0] last_count_q;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	logic irq_q;
	logic int_oe_n_q;
	logic meas_req_q;
	logic pending_q;
	logic [31:0] lp_timer_q;
	logic meas_clk_s1_q;
	logic meas_clk_s2_q;
	logic meas_clk_s3_q;
	logic [COUNT_W-1:0] count_s1_q;
	logic [COUNT_W-1:0] count_s2_q;
	logic int_in_s1_q;
	logic int_in_s2_q;

	pti_pkg::pti_ctrl_t ctrl;
	pti_pkg::pti_mode_t mode;
	assign ctrl = pti_pkg::pti_ctrl_t'(ctrl_q);
	assign mode = ctrl.irq_mode_select;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	wire bus_req = i_read | i_write;
	wire bus_done = bus_req & ~waitrequest_q;
	wire wr_done = bus_done & i_write;
	wire rd_done = bus_done & i_read;
	wire sel_ctrl = (i_address == pti_pkg::OFS_CTRL);
	wire sel_hi = (i_address == pti_pkg::OFS_THR_HI);
	wire sel_lo = (i_address == pti_pkg::OFS_THR_LO);
	wire sel_flags = (i_address == pti_pkg::OFS_FLAGS);
	wire sel_state = (i_address == pti_pkg::OFS_STATE);
	wire sel_istat = (i_address == pti_pkg::OFS_IRQ_STAT);
	wire sel_imask = (i_address == pti_pkg::OFS_IRQ_MASK);
	wire [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
		{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	wire [31:0] wdata_m = i_writedata & be_mask;
	wire [8:0] ctrl_wr = (ctrl_q & ~be_mask[8:0]) | wdata_m[8:0];
	wire [11:0] hi_wr = (thr_hi_q & ~be_mask[11:0]) | wdata_m[11:0];
	wire [11:0] lo_wr = (thr_lo_q & ~be_mask[11:0]) | wdata_m[11:0];

	wire [31:0] state_word = {{(16 - COUNT_W){1'b0}}, last_count_q, 13'h0000,
		int_in_s2_q, armed_q, near_state_q};
	wire [31:0] rd_mux =
		sel_ctrl ? {23'h00_0000, ctrl_q} :
		sel_hi ? {20'h0_0000, thr_hi_q} :
		sel_lo ? {20'h0_0000, thr_lo_q} :
		sel_flags ? {30'h0000_0000, flags_q} :
		sel_state ? state_word :
		sel_istat ? {30'h0000_0000, irq_stat_q} :
		sel_imask ? {30'h0000_0000, irq_mask_q} : 32'h0000_0000;

	// ---------------------------------------------------------------
	// Measurement link
	// ---------------------------------------------------------------

	// A sample is taken on each rising edge of the link clock; in
	// low-power mode only a sample that answers a request counts.
	wire link_rise = meas_clk_s2_q & ~meas_clk_s3_q;
	wire take = link_rise & (~ctrl.low_power_enable | pending_q);

	wire [31:0] lp_period = LP_BASE_CYCLES << ctrl.low_power_period;
	wire lp_expire = ctrl.low_power_enable & (lp_timer_q >= lp_period - 32'h1);

	// ---------------------------------------------------------------
	// Threshold compare, persistence and hysteresis
	// ---------------------------------------------------------------
	wire [11:0] cnt = 12'(count_s2_q);
	wire above = (mode == pti_pkg::PTI_MODE_LOGIC) ? (cnt >= thr_hi_q)
		: (cnt > thr_hi_q);
	wire below = cnt < thr_lo_q;
	wire [2:0] hi_run_n = run_step(above, hi_run_q);
	wire [2:0] lo_run_n = run_step(below, lo_run_q);
	wire hi_hit = above & (hi_run_n >= persist_need(ctrl.persist));
	wire lo_hit = below & (lo_run_n >= persist_need(ctrl.persist));

	wire flag_mode = (mode == pti_pkg::PTI_MODE_NORMAL) |
		(mode == pti_pkg::PTI_MODE_FIRST);
	wire far_ok = (mode == pti_pkg::PTI_MODE_NORMAL) |
		((mode == pti_pkg::PTI_MODE_FIRST) & armed_q);
	wire near_set = take & hi_hit & ~near_state_q & flag_mode;
	wire far_set = take & lo_hit & near_state_q & far_ok;
	wire [1:0] ev_set = {near_set, far_set};

	always_comb begin
		near_state_d = near_state_q;
		if (take && hi_hit) begin
			near_state_d = 1'b1;
		end else if (take && lo_hit) begin
			near_state_d = 1'b0;
		end
	end

	always_comb begin
		armed_d = armed_q;
		if (mode != pti_pkg::PTI_MODE_FIRST) begin
			armed_d = 1'b0;
		end else if (near_set) begin
			armed_d = 1'b1;
		end
	end

	// A completed read clears only the flags that it returned, so an event
	// that lands while the read is in flight is not lost; a new event wins.
	always_comb begin
		flags_d = flags_q;
		if (rd_done && sel_flags) begin
			flags_d = flags_q & ~readdata_q[1:0];
		end
		flags_d = flags_d | ev_set;
	end

	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_done && sel_istat && i_byteenable[0]) begin
			irq_stat_d = irq_stat_q & ~i_writedata[1:0];
		end
		irq_stat_d = irq_stat_d | ev_set;
	end

	// ---------------------------------------------------------------
	// Interrupt pin
	// ---------------------------------------------------------------
	logic pin_assert;
	always_comb begin
		case (mode)
			pti_pkg::PTI_MODE_OFF: pin_assert = 1'b0;
			pti_pkg::PTI_MODE_LOGIC: pin_assert = near_state_q;
			pti_pkg::PTI_MODE_FIRST: pin_assert = |flags_q;
			pti_pkg::PTI_MODE_NORMAL: pin_assert = |flags_q;
			default: pin_assert = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meas_clk_s1_q <= 1'b0;
			meas_clk_s2_q <= 1'b0;
			meas_clk_s3_q <= 1'b0;
			count_s1_q <= '0;
			count_s2_q <= '0;
			int_in_s1_q <= 1'b1;
			int_in_s2_q <= 1'b1;
		end else begin
			meas_clk_s1_q <= i_meas_clk;
			meas_clk_s2_q <= meas_clk_s1_q;
			meas_clk_s3_q <= meas_clk_s2_q;
			count_s1_q <= i_meas_count;
			count_s2_q <= count_s1_q;
			int_in_s1_q <= i_int_in;
			int_in_s2_q <= int_in_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------

	// Each access is answered with waitrequest low on the cycle after
	// it is seen, so every access completes at the second edge.
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else begin
			waitrequest_q <= ~(bus_req & waitrequest_q);
			readdata_q <= rd_mux;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q <= pti_pkg::RST_CTRL;
			thr_hi_q <= pti_pkg::RST_THR_HI;
			thr_lo_q <= pti_pkg::RST_THR_LO;
			irq_mask_q <= pti_pkg::RST_IRQ_MASK;
		end else if (wr_done) begin
			if (sel_ctrl) begin
				ctrl_q <= ctrl_wr;
			end
			if (sel_hi) begin
				thr_hi_q <= hi_wr;
			end
			if (sel_lo) begin
				thr_lo_q <= lo_wr;
			end
			if (sel_imask && i_byteenable[0]) begin
				irq_mask_q <= i_writedata[1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Detection state
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flags_q <= 2'h0;
			irq_stat_q <= 2'h0;
			near_state_q <= 1'b0;
			armed_q <= 1'b0;
			hi_run_q <= 3'h0;
			lo_run_q <= 3'h0;
			last_count_q <= '0;
		end else begin
			flags_q <= flags_d;
			irq_stat_q <= irq_stat_d;
			near_state_q <= near_state_d;
			armed_q <= armed_d;
			if (take) begin
				hi_run_q <= hi_run_n;
				lo_run_q <= lo_run_n;
				last_count_q <= count_s2_q;
			end
		end
	end

	// ---------------------------------------------------------------
	// Low-power sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lp_timer_q <= 32'h0000_0000;
			meas_req_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			meas_req_q <= lp_expire;
			if (!ctrl.low_power_enable || lp_expire) begin
				lp_timer_q <= 32'h0000_0000;
			end else begin
				lp_timer_q <= lp_timer_q + 32'h1;
			end
			if (!ctrl.low_power_enable || take) begin
				pending_q <= 1'b0;
			end else if (lp_expire) begin
				pending_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_q <= 1'b0;
			int_oe_n_q <= 1'b1;
		end else begin
			irq_q <= |(irq_stat_d & irq_mask_q);
			int_oe_n_q <= ~pin_assert;
		end
	end

	assign o_readdata = readdata_q;
	assign o_waitrequest = waitrequest_q;
	assign o_irq = irq_q;
	assign o_meas_req = meas_req_q;
	assign o_int_out = 1'b0;
	assign o_int_oe_n = int_oe_n_q;

endmodule

`default_nettype wire

// [pti_pkg.sv]
/*
 * Shared constants and types of the proximity threshold interrupt block.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none

package pti_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_THR_HI = 5'h04;
	localparam logic [4:0] OFS_THR_LO = 5'h08;
	localparam logic [4:0] OFS_FLAGS = 5'h0C;
	localparam logic [4:0] OFS_STATE = 5'h10;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_PERS_LSB = 4;
	localparam int CTRL_LPEN_BIT = 6;
	localparam int CTRL_LPPER_LSB = 7;
	localparam int FLAG_FAR_BIT = 0;
	localparam int FLAG_NEAR_BIT = 1;
	localparam int STATE_NEAR_BIT = 0;
	localparam int STATE_ARMED_BIT = 1;
	localparam int STATE_COUNT_LSB = 16;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [8:0] RST_CTRL = 9'h000;
	localparam logic [11:0] RST_THR_HI = 12'hFFF;
	localparam logic [11:0] RST_THR_LO = 12'h000;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int LP_BASE_MS = 40;
	localparam int LP_BASE_CYC = LP_BASE_MS * 1000 * CLK_MHZ;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PTI_MODE_OFF = 2'b00,
		PTI_MODE_LOGIC = 2'b01,
		PTI_MODE_FIRST = 2'b10,
		PTI_MODE_NORMAL = 2'b11
	} pti_mode_t;

	typedef struct packed {
		logic [1:0] low_power_period;
		logic low_power_enable;
		logic [1:0] persist;
		pti_mode_t irq_mode_select;
		logic [1:0] unused;
	} pti_ctrl_t;

endpackage

`default_nettype wire

// [pti_link_model.sv]
/* Link-side model of the sensor: one count per link clock pulse.
   Assumes the bench calls sample() and wires both outputs to the block. */
`default_nettype none
module pti_link_model (
	output logic o_clk, // Link clock.
	output logic [11:0] o_count // Proximity count.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_clk = 1'b0;
		o_count = 12'h000;
	end
	// The clock idles low between frames; a stale count is inverted after hold.
	task automatic sample(input logic [11:0] v);
		o_count = v;
		#16 o_clk = 1'b1;
		#16 o_clk = 1'b0;
		#8 o_count = ~v;
	endtask
endmodule
`default_nettype wire

// [pti_top_props.sv]
/* Port checker of the threshold interrupt block.
   Assumes it is bound to every instance of pti_top. */
`default_nettype none
module pti_top_props #(
	parameter int LP_BASE_CYCLES = pti_pkg::LP_BASE_CYC
) (
	input wire logic i_mclk, // Clock.
	input wire logic i_arst_n, // Reset.
	input wire logic [4:0] i_address, // Address.
	input wire logic i_read, // Read.
	input wire logic i_write, // Write.
	input wire logic [31:0] o_readdata, // Read data.
	input wire logic o_waitrequest, // Wait.
	input wire logic o_irq, // Interrupt.
	input wire logic i_meas_clk, // Link clock.
	input wire logic o_meas_req, // Sample request.
	input wire logic o_int_out, // Pin value.
	input wire logic o_int_oe_n // Pin enable.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	// ----
	// Cycles since link edge or bus access, and between requests
	// ----
	logic mc_q;
	logic [3:0] act_q;
	logic [31:0] gap_q;
	wire logic done = (i_read | i_write) & ~o_waitrequest;
	wire logic hit = (i_meas_clk & ~mc_q) | done;
	wire logic [3:0] act_d = hit ? 4'h0 : act_q + {3'h0, act_q != 4'hF};
	wire logic [31:0] gap_d = o_meas_req ? 32'h0 : gap_q + {31'h0, gap_q != 32'hFFFF_FFFF};
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mc_q <= 1'b0;
			act_q <= 4'hF;
			gap_q <= 32'h0;
		end else begin
			mc_q <= i_meas_clk;
			act_q <= act_d;
			gap_q <= gap_d;
		end
	end
	sequence s_req;
		(i_read | i_write) & o_waitrequest;
	endsequence
	sequence s_ans;
		!o_waitrequest ##1 o_waitrequest;
	endsequence
	a_bus_walk: assert property (s_req |=> s_ans)
		else $error("bus answer out of step");
	a_wait_idle: assert property (!(i_read | i_write) |=> o_waitrequest)
		else $error("wait low without request");
	a_rd_unmapped: assert property (s_req and i_read && i_address > 5'h18 |=> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_pin_cause: assert property ($changed(o_int_oe_n) |-> act_q <= 4'h8)
		else $error("pin moved without cause");
	a_irq_cause: assert property ($rose(o_irq) |-> act_q <= 4'h8)
		else $error("irq rose without cause");
	a_req_pulse: assert property (o_meas_req |=> !o_meas_req)
		else $error("request longer than a cycle");
	a_req_gap: assert property (o_meas_req |-> gap_q >= LP_BASE_CYCLES - 2)
		else $error("requests too close");
	a_pin_drive: assert property (o_int_out == 1'b0)
		else $error("pin drives high");
endmodule
bind pti_top pti_top_props #(.LP_BASE_CYCLES(LP_BASE_CYCLES)) u_props (
	.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
	.i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.o_irq(o_irq), .i_meas_clk(i_meas_clk), .o_meas_req(o_meas_req),
	.o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n));
`default_nettype wire

// [test_proximity_threshold_interrupt.sv]
/* Self-checking bench of the threshold interrupt block.
   Assumes the block, its checker and the link model are compiled first. */
`default_nettype none
module test_proximity_threshold_interrupt;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LPB = 64;
	logic i_mclk, i_arst_n, i_read, i_write, o_waitrequest, o_irq, o_meas_req;
	logic o_int_out, o_int_oe_n, lclk;
	logic [4:0] i_address;
	logic [3:0] i_byteenable;
	logic [31:0] i_writedata, o_readdata, rd_q;
	logic [11:0] lcnt, hi, lo;
	int miscompares, cmp_count, n;
	wire logic int_pin = o_int_oe_n ? 1'b1 : o_int_out;
	wire logic [31:0] pin_w = {31'h0, o_int_oe_n};
	wire logic [31:0] irq_w = {31'h0, o_irq};
	pti_link_model lk (.o_clk(lclk), .o_count(lcnt));
	pti_top #(.LP_BASE_CYCLES(LPB)) dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_meas_clk(lclk),
		.i_meas_count(lcnt), .o_meas_req(o_meas_req), .i_int_in(int_pin),
		.o_int_out(o_int_out), .o_int_oe_n(o_int_oe_n));
	function automatic logic [31:0] ctrl(input logic [1:0] m, p, input logic lp,
			input logic [1:0] per);
		return {23'h0, per, lp, p, m, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int k;
		k = 0;
		@(posedge i_mclk);
		i_read <= !w;
		i_write <= w;
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= be;
		// Waitrequest and read data are taken at the edge itself, before it updates them.
		do begin
			@(posedge i_mclk);
			k++;
		end while (o_waitrequest !== 1'b0 && k < 40);
		rd_q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (k >= 40) miscompares++;
		repeat (2) @(posedge i_mclk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd_q, exp);
	endtask
	task automatic smp(input logic [11:0] v);
		lk.sample(v);
		repeat (8) @(posedge i_mclk);
	endtask
	task automatic give_verdict;
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	initial begin
		repeat (30000) @(posedge i_mclk);
		miscompares++;
		give_verdict();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		{i_arst_n, i_read, i_write, i_address, i_writedata} = '0;
		i_byteenable = 4'hF;
		miscompares = 0;
		cmp_count = 0;
		void'($urandom(14132));
		repeat (20) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		rd(5'h00, 32'h0);
		rd(5'h04, 32'hFFF);
		rd(5'h08, 32'h0);
		rd(5'h0C, 32'h0);
		rd(5'h1C, 32'h0);
		chk(pin_w, 32'h1);
		lo = 12'($urandom_range(200, 1500));
		hi = lo + 12'($urandom_range(100, 1500));
		wr(5'h04, {20'h0, hi});
		bus(1'b1, 5'h08, 32'hFFFF, 4'h1);
		rd(5'h08, {24'h0, 8'hFF});
		wr(5'h08, {20'h0, lo});
		wr(5'h18, 32'h2);
		$display("Reset and setup test done");
		for (int p = 1; p < 4; p++) begin
			wr(5'h00, ctrl(2'b11, p[1:0], 1'b0, 2'b00));
			repeat (p) smp(hi + 12'h001);
			rd(5'h0C, 32'h0);
			smp(hi + 12'h001);
			chk(pin_w, 32'h0);
			chk(irq_w, 32'h1);
			smp(hi - 12'h010);
			rd(5'h0C, 32'h2);
			chk(pin_w, 32'h1);
			wr(5'h14, 32'h2);
			chk(irq_w, 32'h0);
			repeat (p) smp(lo - 12'h001);
			rd(5'h0C, 32'h0);
			smp(lo - 12'h001);
			rd(5'h0C, 32'h1);
			chk(irq_w, 32'h0);
			rd(5'h14, 32'h1);
			wr(5'h14, 32'h1);
			$display("Normal mode test, %0d samples, done", p + 1);
		end
		wr(5'h00, ctrl(2'b11, 2'b00, 1'b0, 2'b00));
		smp(hi + 12'h001);
		bus(1'b0, 5'h0C, 32'h0, 4'hF);
		wr(5'h00, ctrl(2'b10, 2'b00, 1'b0, 2'b00));
		smp(lo - 12'h001);
		rd(5'h0C, 32'h0);
		wr(5'h00, ctrl(2'b11, 2'b00, 1'b0, 2'b00));
		smp(lo - 12'h001);
		bus(1'b0, 5'h0C, 32'h0, 4'hF);
		wr(5'h00, ctrl(2'b10, 2'b00, 1'b0, 2'b00));
		smp(hi + 12'h001);
		repeat (3) begin
			smp(hi - 12'h010);
			chk(pin_w, 32'h0);
		end
		rd(5'h0C, 32'h2);
		chk(pin_w, 32'h1);
		smp(lo - 12'h001);
		rd(5'h0C, 32'h1);
		wr(5'h14, 32'h3);
		$display("First-high test done");
		wr(5'h00, ctrl(2'b01, 2'b00, 1'b0, 2'b00));
		smp(hi);
		chk(pin_w, 32'h0);
		smp(lo);
		chk(pin_w, 32'h0);
		rd(5'h10, {4'h0, lo, 16'h0001});
		smp(lo - 12'h001);
		chk(pin_w, 32'h1);
		rd(5'h10, {4'h0, lo - 12'h001, 16'h0004});
		rd(5'h0C, 32'h0);
		$display("Logic mode test done");
		wr(5'h00, ctrl(2'b00, 2'b00, 1'b0, 2'b00));
		repeat (6) begin
			smp(12'($urandom_range(0, 4095)));
			chk(pin_w, 32'h1);
		end
		rd(5'h0C, 32'h0);
		$display("Disabled mode test done");
		for (int c = 0; c < 4; c++) begin
			wr(5'h00, ctrl(2'b11, 2'b00, 1'b1, c[1:0]));
			n = 0;
			while (o_meas_req !== 1'b1 && n < 2000) begin
				@(negedge i_mclk);
				n++;
			end
			n = 0;
			do begin
				@(negedge i_mclk);
				n++;
			end while (o_meas_req !== 1'b1 && n < 2000);
			chk(n, LPB << c);
		end
		wr(5'h00, 32'h0);
		$display("Low-power period test done");
		give_verdict();
	end
endmodule
`default_nettype wire
